// *** hdl/tx_slot_map.sv ***
// Transmit slot and pin map with APB register access.
// Assumes BCLK and FSYNC arrive as pins slower than MCLK/4; samples come
// from logic on MCLK and are taken at each frame start.
//
// Implementation choice: the APB register port.
`timescale 1ns/1ps
module tx_slot_map (
  // Clock and reset
  input  wire logic        MCLK,
  input  wire logic        ARST_N,
  // APB slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [11:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic [31:0]      PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // Channel samples
  input  wire logic [31:0] CH1_SAMPLE,
  input  wire logic [31:0] CH2_SAMPLE,
  output logic             SAMPLE_TAKEN,
  // Serial pins
  input  wire logic        BCLK,
  input  wire logic        FSYNC,
  output logic             DOUT_PRIMARY,
  output logic             DOUT_PRIMARY_OE,
  output logic             DOUT_SECONDARY,
  output logic             DOUT_SECONDARY_OE
);

  ////////////////////////////////////////////////////////////////////////////
  // Register file
  ////////////////////////////////////////////////////////////////////////////
  logic [7:0]  pin_sel_r, pin_sel_nxt;
  logic [7:0]  ch1_cfg_r, ch1_cfg_nxt;
  logic [7:0]  ch2_cfg_r, ch2_cfg_nxt;
  logic [1:0]  format_r, format_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic        wr_en;
  logic        rd_setup;
  logic        hit;
  logic [31:0] rd_val;
  logic [3:0]  status;

  // Address decode; unmapped words read zero and flag an error
  always_comb begin
    hit    = 1'b1;
    rd_val = 32'h0000_0000;
    if (PADDR == {2'b00, tx_map_pkg::PIN_SEL_IDX, 2'b00}) begin
      rd_val = {24'h00_0000, pin_sel_r};
    end else if (PADDR == {2'b00, tx_map_pkg::CH1_CFG_IDX, 2'b00}) begin
      rd_val = {24'h00_0000, ch1_cfg_r};
    end else if (PADDR == {2'b00, tx_map_pkg::CH2_CFG_IDX, 2'b00}) begin
      rd_val = {24'h00_0000, ch2_cfg_r};
    end else if (PADDR == {2'b00, tx_map_pkg::FORMAT_IDX, 2'b00}) begin
      rd_val = {30'h0000_0000, format_r};
    end else if (PADDR == {2'b00, tx_map_pkg::STATUS_IDX, 2'b00}) begin
      rd_val = {28'h000_0000, status};
    end else begin
      hit = 1'b0;
    end
  end

  assign wr_en    = PSEL && PENABLE && PWRITE && hit;
  assign rd_setup = PSEL && !PENABLE;
  // Read data is captured in the setup phase so PRDATA comes from a flop
  assign PREADY   = 1'b1;
  assign PSLVERR  = PSEL && PENABLE && !hit;
  assign PRDATA   = prdata_r;

  // Register next values; reserved config bits never take a write
  always_comb begin
    pin_sel_nxt = pin_sel_r;
    ch1_cfg_nxt = ch1_cfg_r;
    ch2_cfg_nxt = ch2_cfg_r;
    format_nxt  = format_r;
    prdata_nxt  = prdata_r;
    if (rd_setup) begin
      prdata_nxt = rd_val;
    end
    if (wr_en) begin
      if (PADDR == {2'b00, tx_map_pkg::PIN_SEL_IDX, 2'b00}) begin
        pin_sel_nxt = PWDATA[7:0];
      end else if (PADDR == {2'b00, tx_map_pkg::CH1_CFG_IDX, 2'b00}) begin
        ch1_cfg_nxt = PWDATA[7:0] & tx_map_pkg::CFG_WR_MASK;
      end else if (PADDR == {2'b00, tx_map_pkg::CH2_CFG_IDX, 2'b00}) begin
        ch2_cfg_nxt = PWDATA[7:0] & tx_map_pkg::CFG_WR_MASK;
      end else if (PADDR == {2'b00, tx_map_pkg::FORMAT_IDX, 2'b00}) begin
        format_nxt = PWDATA[1:0];
      end
    end
  end

  // Register storage with documented reset values
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      pin_sel_r <= tx_map_pkg::PIN_SEL_RST;
      ch1_cfg_r <= tx_map_pkg::CH1_CFG_RST;
      ch2_cfg_r <= tx_map_pkg::CH2_CFG_RST;
      format_r  <= tx_map_pkg::FORMAT_RST;
      prdata_r  <= 32'h0000_0000;
    end else begin
      pin_sel_r <= pin_sel_nxt;
      ch1_cfg_r <= ch1_cfg_nxt;
      ch2_cfg_r <= ch2_cfg_nxt;
      format_r  <= format_nxt;
      prdata_r  <= prdata_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and edge detection
  ////////////////////////////////////////////////////////////////////////////
  logic [1:0] bclk_sync_r, fsync_sync_r;
  logic       bclk_d_r, fsync_d_r, fsync_smp_r, fsync_prev_r, fsync_old_r;
  logic       bclk_rise, bclk_fall;

  // Two sync flops and a delay flop per pin; the first stage feeds no logic
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      bclk_sync_r  <= 2'h0;
      fsync_sync_r <= 2'h0;
      bclk_d_r     <= 1'b0;
      fsync_d_r    <= 1'b0;
    end else begin
      bclk_sync_r  <= {bclk_sync_r[0], BCLK};
      fsync_sync_r <= {fsync_sync_r[0], FSYNC};
      bclk_d_r     <= bclk_sync_r[1];
      fsync_d_r    <= fsync_sync_r[1];
    end
  end

  assign bclk_rise = bclk_sync_r[1] && !bclk_d_r;
  assign bclk_fall = !bclk_sync_r[1] && bclk_d_r;

  ////////////////////////////////////////////////////////////////////////////
  // Framer: bit counter and half tracking
  ////////////////////////////////////////////////////////////////////////////
  logic [10:0] bit_cnt_r, bit_cnt_nxt;
  logic        right_r, right_nxt;
  logic [31:0] ch1_data_r, ch1_data_nxt;
  logic [31:0] ch2_data_r, ch2_data_nxt;
  logic        taken_r, taken_nxt;
  logic        smp_nxt, prev_nxt, old_nxt;
  logic        fs_edge;
  logic        fs_high;

  // Frame sync is sampled on the receiver's edge, data moves on the other one
  always_comb begin
    smp_nxt      = fsync_smp_r;
    prev_nxt     = fsync_prev_r;
    old_nxt      = fsync_old_r;
    bit_cnt_nxt  = bit_cnt_r;
    right_nxt    = right_r;
    ch1_data_nxt = ch1_data_r;
    ch2_data_nxt = ch2_data_r;
    taken_nxt    = 1'b0;
    fs_high      = fsync_smp_r;
    fs_edge      = 1'b0;
    if (bclk_rise) begin
      smp_nxt  = fsync_d_r;
      prev_nxt = fsync_smp_r;
      old_nxt  = fsync_prev_r;
    end
    if (bclk_fall) begin
      bit_cnt_nxt = bit_cnt_r + 11'h001;
      if (bit_cnt_r == 11'h7ff - 11'h001) begin
        bit_cnt_nxt = bit_cnt_r;                   // Park past the last slot
      end
      if (format_r == 2'(tx_map_pkg::FMT_TDM)) begin
        fs_edge = fs_high && !fsync_prev_r;
      end else if (format_r == 2'(tx_map_pkg::FMT_I2S)) begin
        // I2S sees the edge one bit late, so the old half keeps its last bit
        fs_edge = fsync_prev_r != fsync_old_r;
      end else begin
        fs_edge = fs_high != fsync_prev_r;
      end
      if (fs_edge) begin
        bit_cnt_nxt = 11'h000;
        right_nxt   = (format_r == 2'(tx_map_pkg::FMT_I2S)) ? fsync_prev_r
                    : (format_r == 2'(tx_map_pkg::FMT_LJ)) ? !fs_high : 1'b0;
        if (!right_nxt) begin
          ch1_data_nxt = CH1_SAMPLE;
          ch2_data_nxt = CH2_SAMPLE;
          taken_nxt    = 1'b1;
        end
      end
    end
  end

  // Framer state; counter starts parked so nothing drives before a frame
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      fsync_smp_r  <= 1'b0;
      fsync_prev_r <= 1'b0;
      fsync_old_r  <= 1'b0;
      bit_cnt_r    <= 11'h7fe;
      right_r      <= 1'b0;
      ch1_data_r   <= 32'h0000_0000;
      ch2_data_r   <= 32'h0000_0000;
      taken_r      <= 1'b0;
    end else begin
      fsync_smp_r  <= smp_nxt;
      fsync_prev_r <= prev_nxt;
      fsync_old_r  <= old_nxt;
      bit_cnt_r    <= bit_cnt_nxt;
      right_r      <= right_nxt;
      ch1_data_r   <= ch1_data_nxt;
      ch2_data_r   <= ch2_data_nxt;
      taken_r      <= taken_nxt;
    end
  end

  assign SAMPLE_TAKEN = taken_r;

  ////////////////////////////////////////////////////////////////////////////
  // Slot match and pin drivers
  ////////////////////////////////////////////////////////////////////////////
  logic       ch1_act, ch2_act;
  logic [4:0] bit_idx;
  logic       pri_nxt, pri_oe_nxt, sec_nxt, sec_oe_nxt;
  logic       pri_r, pri_oe_r, sec_r, sec_oe_r;

  slot_match u_ch1 (
    .cfg        (ch1_cfg_r),
    .fmt        (format_r),
    .right_half (right_nxt),
    .bit_cnt    (bit_cnt_nxt),
    .active     (ch1_act)
  );

  slot_match u_ch2 (
    .cfg        (ch2_cfg_r),
    .fmt        (format_r),
    .right_half (right_nxt),
    .bit_cnt    (bit_cnt_nxt),
    .active     (ch2_act)
  );

  // MSB first within each slot
  assign bit_idx = 5'h1f - bit_cnt_nxt[4:0];

  // Unclaimed slots float; channel 1 wins if two channels share a slot and pin
  always_comb begin
    pri_nxt    = pri_r;
    pri_oe_nxt = pri_oe_r;
    sec_nxt    = sec_r;
    sec_oe_nxt = sec_oe_r;
    if (bclk_fall) begin
      pri_nxt    = 1'b0;
      pri_oe_nxt = 1'b0;
      sec_nxt    = 1'b0;
      sec_oe_nxt = 1'b0;
      if (ch2_act && !pin_sel_r[1]) begin
        pri_nxt    = ch2_data_nxt[bit_idx];
        pri_oe_nxt = 1'b1;
      end
      if (ch2_act && pin_sel_r[1]) begin
        sec_nxt    = ch2_data_nxt[bit_idx];
        sec_oe_nxt = 1'b1;
      end
      if (ch1_act && !pin_sel_r[0]) begin
        pri_nxt    = ch1_data_nxt[bit_idx];
        pri_oe_nxt = 1'b1;
      end
      if (ch1_act && pin_sel_r[0]) begin
        sec_nxt    = ch1_data_nxt[bit_idx];
        sec_oe_nxt = 1'b1;
      end
    end
  end

  // Pin flops; released to high impedance at reset
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      pri_r    <= 1'b0;
      pri_oe_r <= 1'b0;
      sec_r    <= 1'b0;
      sec_oe_r <= 1'b0;
    end else begin
      pri_r    <= pri_nxt;
      pri_oe_r <= pri_oe_nxt;
      sec_r    <= sec_nxt;
      sec_oe_r <= sec_oe_nxt;
    end
  end

  assign DOUT_PRIMARY      = pri_r;
  assign DOUT_PRIMARY_OE   = pri_oe_r;
  assign DOUT_SECONDARY    = sec_r;
  assign DOUT_SECONDARY_OE = sec_oe_r;
  assign status            = {sec_oe_r, pri_oe_r, right_r, fsync_smp_r};

endmodule

// *** hdl/tx_map_pkg.sv ***
// Constants shared by the transmit slot and pin map block.
// Assumes an APB slave with 32-bit data, registers one per aligned word.
// How it works
// - Each channel's select bit: 0 sends it on the primary pin, 1 on the secondary.
// - Channel 1 output enable cleared: its slot stays high impedance.
// - Channel 1 output enable set: the channel 1 sample goes out in its slot.
// - Slot values 0 to 15: TDM slot n, or left-half slot n otherwise.
// - Slot values 16 to 31: TDM slot n, or right-half slot n minus 16.
// - Pin select register at index 0x1d resets to 0x00, all on primary pin.
// - Channel 1 config register at index 0x1e resets to 0x20.
// - Channel 2 config register at index 0x1f resets to 0x21.
package tx_map_pkg;
  // Register indexes; byte address is four times the index
  localparam logic [7:0]  PIN_SEL_IDX   = 8'h1d;
  localparam logic [7:0]  CH1_CFG_IDX   = 8'h1e;
  localparam logic [7:0]  CH2_CFG_IDX   = 8'h1f;
  localparam logic [7:0]  FORMAT_IDX    = 8'h30;
  localparam logic [7:0]  STATUS_IDX    = 8'h31;
  // Reset values
  localparam logic [7:0]  PIN_SEL_RST   = 8'h00;
  localparam logic [7:0]  CH1_CFG_RST   = 8'h20;
  localparam logic [7:0]  CH2_CFG_RST   = 8'h21;
  localparam logic [1:0]  FORMAT_RST    = 2'h0;
  // Channel config field layout
  localparam int          CFG_EN_BIT    = 5;
  localparam int          SLOT_MSB      = 4;
  localparam logic [7:0]  CFG_WR_MASK   = 8'h3f;
  // Serial framing
  localparam int          SLOT_BITS     = 32;
  localparam int          CNT_W         = 11;
  localparam int          NUM_CH        = 8;
  typedef enum logic [1:0] {FMT_TDM, FMT_I2S, FMT_LJ, FMT_RSVD} format_t;
endpackage

// *** hdl/slot_match.sv ***
// One transmit channel: decides whether the current bit belongs to its slot.
// Assumes the bit counter and half flag come from the framer on the same clock.
`timescale 1ns/1ps
module slot_match (
  // Channel configuration
  input  wire logic [7:0]  cfg,
  // Framer position
  input  wire logic [1:0]  fmt,
  input  wire logic        right_half,
  input  wire logic [10:0] bit_cnt,
  // Result
  output logic             active
);
  logic [4:0] slot;
  logic       in_range;

  // Slot decode differs between TDM and the two-half formats
  always_comb begin
    slot     = cfg[tx_map_pkg::SLOT_MSB:0];
    in_range = 1'b0;
    if (fmt == 2'(tx_map_pkg::FMT_TDM)) begin
      in_range = (bit_cnt[10] == 1'b0) && (bit_cnt[9:5] == slot);
    end else begin
      // Upper half of the slot codes means the right half, slot minus 16
      in_range = (bit_cnt[10:9] == 2'b00) && (slot[4] == right_half)
                 && (bit_cnt[8:5] == slot[3:0]);
    end
    active = in_range && cfg[tx_map_pkg::CFG_EN_BIT];
  end
endmodule

// *** verification/tx_slot_map_assertions.sv ***
// Port checker for the transmit slot map.
// Assumes only channels 1 and 2 drive pins and no write lands mid-frame.
`timescale 1ns/1ps
module tx_slot_map_assertions (
  // Clock and reset
  input wire logic        MCLK,
  input wire logic        ARST_N,
  // APB
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic        PREADY,
  input wire logic        PSLVERR,
  // Pin enables
  input wire logic        DOUT_PRIMARY_OE,
  input wire logic        DOUT_SECONDARY_OE
);
  logic [7:0] sel_r, c1_r, c2_r, sel_nxt, c1_nxt, c2_nxt;
  wire        wr = PSEL && PENABLE && PWRITE && PREADY;
  wire        rd = PSEL && PENABLE && !PWRITE;
  wire        pe = DOUT_PRIMARY_OE;
  wire        se = DOUT_SECONDARY_OE;
  ////////////////////////////////////////////////////////////
  // Shadow of the writable fields; top config bits never stick
  always_comb begin
    sel_nxt = (wr && PADDR == 12'h074) ? PWDATA[7:0] : sel_r;
    c1_nxt  = (wr && PADDR == 12'h078) ? {2'h0, PWDATA[5:0]} : c1_r;
    c2_nxt  = (wr && PADDR == 12'h07c) ? {2'h0, PWDATA[5:0]} : c2_r;
  end
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      sel_r <= tx_map_pkg::PIN_SEL_RST;
      c1_r  <= tx_map_pkg::CH1_CFG_RST;
      c2_r  <= tx_map_pkg::CH2_CFG_RST;
    end else begin
      sel_r <= sel_nxt;
      c1_r  <= c1_nxt;
      c2_r  <= c2_nxt;
    end
  end
  ////////////////////////////////////////////////////////////
  default clocking @(posedge MCLK); endclocking
  default disable iff (!ARST_N);
  a_sel_read: assert property (rd && PADDR == 12'h074 |-> PRDATA == {24'h0, sel_r})
    else $error("pin select readback differs");
  a_ch1_read: assert property (rd && PADDR == 12'h078 |-> PRDATA == {24'h0, c1_r})
    else $error("channel 1 config readback differs");
  a_ch2_read: assert property (rd && PADDR == 12'h07c |-> PRDATA == {24'h0, c2_r})
    else $error("channel 2 config readback differs");
  a_secondary_src: assert property (se |-> (c1_r[5] && sel_r[0]) || (c2_r[5] && sel_r[1]))
    else $error("secondary pin driven with no channel routed");
  a_primary_src: assert property (pe |-> (c1_r[5] && !sel_r[0]) || (c2_r[5] && !sel_r[1]))
    else $error("primary pin driven with no channel routed");
  a_all_off: assert property (!c1_r[5] && !c2_r[5] |-> !pe && !se)
    else $error("pin driven with both channels off");
  a_quiet_release: assert property ($rose(ARST_N) |-> (!pe && !se)[*2])
    else $error("pin driven right after reset");
  a_unmapped_err: assert property (rd && PADDR == 12'h100 |-> PSLVERR && PRDATA == 32'h0 && PREADY)
    else $error("unmapped read not refused");
  c_secondary: cover property ($rose(se));
  c_primary: cover property ($rose(pe));
  c_unmapped: cover property (rd && PSLVERR);
endmodule
bind tx_slot_map tx_slot_map_assertions chk (.MCLK, .ARST_N, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA,
  .PRDATA, .PREADY, .PSLVERR, .DOUT_PRIMARY_OE, .DOUT_SECONDARY_OE);

// *** verification/serial_host_model.sv ***
// Host end of the serial link: makes bit clock and frame sync, records both pins.
// Assumes frame() is called while idle; the bit clock rests low between frames.
`timescale 1ns/1ps
module serial_host_model (
  // Clock
  input  wire logic        MCLK,
  // Link
  output logic             BCLK,
  output logic             FSYNC,
  input  wire logic        DOUT_PRIMARY,
  input  wire logic        DOUT_PRIMARY_OE,
  input  wire logic        DOUT_SECONDARY,
  input  wire logic        DOUT_SECONDARY_OE,
  // Per pin: first driven bit, driven bit count, word
  output logic [63:0]      res_p,
  output logic [63:0]      res_s,
  output logic             done
);
  initial begin
    BCLK = 1'b0;
    FSYNC = 1'b0;
    done = 1'b0;
  end
  function automatic logic [63:0] cap(input logic [63:0] r, input int k, input logic d);
    cap = r;
    if (r[63:48] == 16'hffff)
      cap[63:48] = k[15:0];
    cap[47:32] = r[47:32] + 16'h1;
    cap[31:0] = {r[30:0], d};
  endfunction
  ////////////////////////////////////////////////////////////
  // Six MCLK per half bit leaves room for the input synchroniser
  task automatic frame(input logic [1:0] fmt, input logic [11:0] len, input logic [11:0] half);
    int k;
    logic lvl;
    logic [63:0] p, s;
    p = {16'hffff, 48'h0};
    s = {16'hffff, 48'h0};
    lvl = (fmt == 2'h2);
    for (k = -2; k < int'(len) + 2; k++) begin
      @(posedge MCLK);
      BCLK <= 1'b0;
      FSYNC <= (fmt == 2'h0) ? (k == -1) : ((k >= -1 && k + 1 < int'(half)) ? lvl : !lvl);
      repeat (6) @(posedge MCLK);
      BCLK <= 1'b1;
      if (k >= 0 && DOUT_PRIMARY_OE === 1'b1)
        p = cap(p, k, DOUT_PRIMARY);
      if (k >= 0 && DOUT_SECONDARY_OE === 1'b1)
        s = cap(s, k, DOUT_SECONDARY);
      repeat (5) @(posedge MCLK);
    end
    @(posedge MCLK);
    BCLK <= 1'b0;
    res_p <= p;
    res_s <= s;
    done <= 1'b1;
    @(posedge MCLK);
    done <= 1'b0;
  endtask
endmodule

// *** verification/tb_tx_slot_map.sv ***
// Self-checking bench for the transmit slot map.
// Assumes the host model owns the serial clocks and APB answers at once.
`timescale 1ns/1ps
module tb_tx_slot_map;
  logic        MCLK, ARST_N, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, SAMPLE_TAKEN;
  logic        BCLK, FSYNC, DOUT_PRIMARY, DOUT_PRIMARY_OE, DOUT_SECONDARY, DOUT_SECONDARY_OE, done;
  logic [11:0] PADDR;
  logic [31:0] PWDATA, PRDATA, CH1_SAMPLE, CH2_SAMPLE, r;
  logic [63:0] exp_q[$], res_p, res_s;
  logic [47:0] t;
  int          failures = 0, checks = 0, cycles = 0, seed = 81, i, taken = 0;
  // Case: format, pin select, ch1 cfg, ch2 cfg, frame bits, half bits
  logic [47:0] tbl[9] = '{48'h0020_0008_0000, 48'h0121_0008_0000, 48'h000f_2108_0000,
                          48'h003f_0040_0000, 48'h2030_0008_0040, 48'h102f_0040_0200,
                          48'h213f_0040_0200, 48'h0220_2208_0000, 48'h0000_0008_0000};
  tx_slot_map uut (.MCLK, .ARST_N, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR,
    .CH1_SAMPLE, .CH2_SAMPLE, .SAMPLE_TAKEN, .BCLK, .FSYNC, .DOUT_PRIMARY, .DOUT_PRIMARY_OE,
    .DOUT_SECONDARY, .DOUT_SECONDARY_OE);
  serial_host_model host (.MCLK, .BCLK, .FSYNC, .DOUT_PRIMARY, .DOUT_PRIMARY_OE, .DOUT_SECONDARY,
    .DOUT_SECONDARY_OE, .res_p, .res_s, .done);
  ////////////////////////////////////////////////////////////
  // First bit of a slot; right half codes start at the half boundary, I2S one bit late
  function automatic logic [15:0] pos(input logic [3:0] f, input logic [4:0] s, input logic [11:0] h);
    if (f == 4'h0)
      return {6'h0, s, 5'h0};
    return (s[4] ? {4'h0, h} : 16'h0) + {7'h0, s[3:0], 5'h0} + {15'h0, f == 4'h1};
  endfunction
  function automatic logic [63:0] want(input logic pin);
    // Channel 1 is looked at last because it wins a shared pin and slot
    want = {16'hffff, 48'h0};
    if (t[29] && t[41] == pin)
      want = {pos(t[47:44], t[28:24], t[11:0]), 16'h0020, CH2_SAMPLE};
    if (t[37] && t[40] == pin)
      want = {pos(t[47:44], t[36:32], t[11:0]), 16'h0020, CH1_SAMPLE};
  endfunction
  task automatic check(input logic [63:0] seen, input logic [63:0] w);
    checks++;
    if (seen !== w) begin
      failures++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, w);
    end
  endtask
  task automatic give_verdict();
    if (failures == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Setup then access; release only after the edge that sees ready
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= wr;
    PADDR <= a;
    PWDATA <= d;
    @(posedge MCLK);
    PENABLE <= 1'b1;
    do @(posedge MCLK); while (PREADY !== 1'b1);
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge MCLK);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    exp_q.push_back({32'h0, e});
    apb(1'b0, a, 32'h0);
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    MCLK = 1'b0;
    forever #4 MCLK = ~MCLK;
  end
  // Results are matched in arrival order; the cycle ceiling cuts a hang short
  always @(posedge MCLK) begin
    if (SAMPLE_TAKEN)
      taken++;
    if (PSEL && PENABLE && PREADY && !PWRITE)
      check({32'h0, PRDATA}, exp_q.pop_front());
    if (done) begin
      check(res_p, exp_q.pop_front());
      check(res_s, exp_q.pop_front());
      check(64'(taken), 64'h1);
      taken = 0;
    end
    cycles++;
    if (cycles == 70000) begin
      failures++;
      give_verdict();
    end
  end
  initial begin
    {ARST_N, PSEL, PENABLE, PWRITE, PADDR, PWDATA, CH1_SAMPLE, CH2_SAMPLE} = '0;
    repeat (4) @(posedge MCLK);
    ARST_N <= 1'b1;
    @(posedge MCLK);
    rd(12'h074, 32'h0);
    rd(12'h078, 32'h20);
    rd(12'h07c, 32'h21);
    rd(12'h100, 32'h0);
    apb(1'b1, 12'h078, 32'hff);
    rd(12'h078, 32'h3f);
    for (i = 0; i < 9; i++) begin
      t = tbl[i];
      r = $random(seed);
      apb(1'b1, 12'h074, {r[31:2], t[41:40]});
      apb(1'b1, 12'h078, {24'h0, t[39:32]});
      apb(1'b1, 12'h07c, {24'h0, t[31:24]});
      apb(1'b1, 12'h0c0, {28'h0, t[47:44]});
      rd(12'h074, {24'h0, r[7:2], t[41:40]});
      CH1_SAMPLE <= $random(seed);
      CH2_SAMPLE <= $random(seed);
      @(posedge MCLK);
      exp_q.push_back(want(1'b0));
      exp_q.push_back(want(1'b1));
      host.frame(t[45:44], t[23:12], t[11:0]);
    end
    repeat (4) @(posedge MCLK);
    give_verdict();
  end
endmodule
